// File: dsp_multiply_accumulate.sv
// Multiply and multiply-accumulate slice with an Avalon-MM register port.
module dsp_multiply_accumulate #(
  parameter int OP_W = 18,
  parameter int ACC_W = 52
) (
  input wire logic core_clk_in,
  input wire logic nrst_in,
  input wire logic [3:0] avs_address_in,
  input wire logic avs_read_in,
  input wire logic avs_write_in,
  input wire logic [31:0] avs_writedata_in,
  input wire logic [3:0] avs_byteenable_in,
  output logic [31:0] avs_readdata_out,
  output logic avs_waitrequest_out,
  output logic irq_out,
  input wire logic valid_in,
  input wire logic [OP_W-1:0] a_in,
  input wire logic [OP_W-1:0] b_in,
  input wire logic [OP_W-1:0] a_shift_in,
  input wire logic [OP_W-1:0] b_shift_in,
  input wire logic signed_in,
  input wire logic sub_in,
  output logic [OP_W-1:0] a_shift_out,
  output logic [OP_W-1:0] b_shift_out,
  output logic [ACC_W-1:0] result_out,
  output logic result_valid_out,
  output logic overflow_out
);
  localparam int P_W = 2 * OP_W;

  // Byte-lane merge, used for every writable word
  function automatic logic [31:0] merge_bytes(input logic [31:0] old_v, input logic [31:0] new_v,
                                              input logic [3:0] be);
    logic [31:0] m;
    m = old_v;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        m[8*i +: 8] = new_v[8*i +: 8];
      end
    end
    return m;
  endfunction

  // ---------------- Register bus ----------------
  logic wait_r;
  logic [31:0] rdata_r;
  logic [dsp_mac_pkg::CTRL_W-1:0] ctrl_r;
  logic [dsp_mac_pkg::ST_W-1:0] status_r, mask_r;
  logic irq_r;

  wire logic req = avs_read_in | avs_write_in;
  // A request is taken in the one cycle where waitrequest is low
  wire logic take = req & ~wait_r;
  wire logic wr_ctrl = take & avs_write_in & (avs_address_in == dsp_mac_pkg::CTRL_OFF);
  wire logic wr_mask = take & avs_write_in & (avs_address_in == dsp_mac_pkg::MASK_OFF);
  wire logic rd_status = take & avs_read_in & (avs_address_in == dsp_mac_pkg::STATUS_OFF);
  wire logic [31:0] ctrl_word = {21'h000000, 1'b0, ctrl_r};
  wire logic [31:0] ctrl_merged = merge_bytes(ctrl_word, avs_writedata_in, avs_byteenable_in);
  wire logic [31:0] mask_merged = merge_bytes({30'h00000000, mask_r}, avs_writedata_in, avs_byteenable_in);
  // Clearing is a command, not a stored setting, so it never reads back as set
  wire logic acc_clr = wr_ctrl & ctrl_merged[dsp_mac_pkg::CTRL_ACC_CLR];

  wire logic mac_ok = (OP_W <= dsp_mac_pkg::MAC_MAX_OP_W);
  wire logic mac_mode = ctrl_r[dsp_mac_pkg::CTRL_MAC] & mac_ok;
  wire logic in_en = ctrl_r[dsp_mac_pkg::CTRL_IN_EN];
  wire logic pipe_en = ctrl_r[dsp_mac_pkg::CTRL_PIPE_EN];
  wire logic out_en = ctrl_r[dsp_mac_pkg::CTRL_OUT_EN];
  wire logic a_shift = ctrl_r[dsp_mac_pkg::CTRL_A_SHIFT];
  wire logic b_shift = ctrl_r[dsp_mac_pkg::CTRL_B_SHIFT];
  wire logic sgn_now = ctrl_r[dsp_mac_pkg::CTRL_SIGN_DYN] ? signed_in : ctrl_r[dsp_mac_pkg::CTRL_SIGNED];
  wire logic sub_now = ctrl_r[dsp_mac_pkg::CTRL_SUB_DYN] ? sub_in : ctrl_r[dsp_mac_pkg::CTRL_SUB];

  // ---------------- Input registers ----------------
  logic [OP_W-1:0] a_reg_r, b_reg_r;
  logic v_reg_r, sgn_reg_r, sub_reg_r;
  wire logic [OP_W-1:0] a_load = a_shift ? a_shift_in : a_in;
  wire logic [OP_W-1:0] b_load = b_shift ? b_shift_in : b_in;

  always_ff @(posedge core_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      a_reg_r <= '0;
      b_reg_r <= '0;
      v_reg_r <= 1'b0;
      sgn_reg_r <= 1'b0;
      sub_reg_r <= 1'b0;
    end else begin
      a_reg_r <= a_load;
      b_reg_r <= b_load;
      v_reg_r <= valid_in;
      sgn_reg_r <= sgn_now;
      sub_reg_r <= sub_now;
    end
  end

  wire logic [OP_W-1:0] a_op = in_en ? a_reg_r : a_in;
  wire logic [OP_W-1:0] b_op = in_en ? b_reg_r : b_in;
  wire logic v_op = in_en ? v_reg_r : valid_in;
  wire logic sgn_op = in_en ? sgn_reg_r : sgn_now;
  wire logic sub_op = in_en ? sub_reg_r : sub_now;

  logic [P_W-1:0] prod;
  logic prod_v, prod_sgn, prod_sub;

  product_stage #(.OP_W(OP_W)) u_product (
    .core_clk_in(core_clk_in),
    .nrst_in(nrst_in),
    .pipe_en_in(pipe_en),
    .valid_in(v_op),
    .signed_in(sgn_op),
    .sub_in(sub_op),
    .a_in(a_op),
    .b_in(b_op),
    .prod_out(prod),
    .valid_out(prod_v),
    .signed_out(prod_sgn),
    .sub_out(prod_sub)
  );

  wire logic [ACC_W-1:0] p_ext = {{(ACC_W-P_W){prod_sgn & prod[P_W-1]}}, prod};

  // ---------------- Accumulator ----------------
  logic [ACC_W-1:0] acc_r, out_stage_r, result_r;
  logic ovf_r, ovf_out_r, out_v_r, result_v_r;

  wire logic acc_v = mac_mode & prod_v;
  wire logic [ACC_W:0] acc_sum = {1'b0, acc_r} + {1'b0, p_ext};
  wire logic [ACC_W:0] acc_dif = {1'b0, acc_r} - {1'b0, p_ext};
  wire logic [ACC_W:0] acc_nxt = prod_sub ? acc_dif : acc_sum;
  wire logic acc_msb = acc_r[ACC_W-1];
  wire logic p_msb = p_ext[ACC_W-1];
  wire logic r_msb = acc_nxt[ACC_W-1];
  // Carry out on add, borrow on subtract: the result rolled past zero
  wire logic ovf_uns = acc_nxt[ACC_W];
  wire logic ovf_sgn = prod_sub ? ((acc_msb != p_msb) && (r_msb != acc_msb))
                                : ((acc_msb == p_msb) && (r_msb != acc_msb));
  wire logic ovf_now = acc_v & (prod_sgn ? ovf_sgn : ovf_uns);

  always_ff @(posedge core_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      acc_r <= '0;
      ovf_r <= 1'b0;
    end else begin
      if (acc_clr) begin
        acc_r <= '0;
      end else if (acc_v) begin
        acc_r <= acc_nxt[ACC_W-1:0];
      end
      ovf_r <= ovf_now & ~acc_clr;
    end
  end

  // ---------------- Output stage ----------------
  // The port flop costs one cycle in every mode but keeps every output glitch free
  wire logic [ACC_W-1:0] result_nxt = mac_mode ? acc_r : (out_en ? out_stage_r : p_ext);
  logic acc_v_d_r;
  wire logic result_v_nxt = mac_mode ? (acc_v_d_r) : (out_en ? out_v_r : prod_v);

  always_ff @(posedge core_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      out_stage_r <= '0;
      out_v_r <= 1'b0;
      acc_v_d_r <= 1'b0;
      result_r <= '0;
      result_v_r <= 1'b0;
      ovf_out_r <= 1'b0;
    end else begin
      out_stage_r <= p_ext;
      out_v_r <= prod_v;
      acc_v_d_r <= acc_v;
      result_r <= result_nxt;
      result_v_r <= result_v_nxt;
      ovf_out_r <= ovf_r;
    end
  end

  // ---------------- Status, mask, interrupt ----------------
  wire logic [dsp_mac_pkg::ST_W-1:0] st_evt = {result_v_r, ovf_out_r};
  // An event in the clearing read's own cycle survives the clear
  wire logic [dsp_mac_pkg::ST_W-1:0] status_nxt = (rd_status ? '0 : status_r) | st_evt;
  wire logic [dsp_mac_pkg::ST_W-1:0] mask_nxt = wr_mask ? mask_merged[dsp_mac_pkg::ST_W-1:0] : mask_r;

  logic [31:0] rdata_nxt;
  always_comb begin
    unique case (avs_address_in)
      dsp_mac_pkg::CTRL_OFF: rdata_nxt = ctrl_word;
      dsp_mac_pkg::STATUS_OFF: rdata_nxt = {30'h00000000, status_r};
      dsp_mac_pkg::MASK_OFF: rdata_nxt = {30'h00000000, mask_r};
      dsp_mac_pkg::RESULT_OFF: rdata_nxt = result_r[31:0];
      default: rdata_nxt = 32'h00000000;
    endcase
  end

  always_ff @(posedge core_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      wait_r <= 1'b1;
      rdata_r <= 32'h00000000;
      ctrl_r <= dsp_mac_pkg::CTRL_RST;
      status_r <= dsp_mac_pkg::ST_RST;
      mask_r <= dsp_mac_pkg::ST_RST;
      irq_r <= 1'b0;
    end else begin
      wait_r <= wait_r ? ~req : 1'b1;
      if (req && wait_r) begin
        rdata_r <= avs_read_in ? rdata_nxt : 32'h00000000;
      end
      if (wr_ctrl) begin
        ctrl_r <= ctrl_merged[dsp_mac_pkg::CTRL_W-1:0];
      end
      status_r <= status_nxt;
      mask_r <= mask_nxt;
      irq_r <= |(status_nxt & mask_nxt);
    end
  end

  assign avs_waitrequest_out = wait_r;
  assign avs_readdata_out = rdata_r;
  assign irq_out = irq_r;
  assign a_shift_out = a_reg_r;
  assign b_shift_out = b_reg_r;
  assign result_out = result_r;
  assign result_valid_out = result_v_r;
  assign overflow_out = ovf_out_r;

  // ---------------- Checks ----------------
  acc_hold_a: assert property (@(posedge core_clk_in) disable iff (!nrst_in)
    (!acc_v && !acc_clr) |=> acc_r == $past(acc_r))
    else $error("accumulator changed without a valid product");
  acc_add_a: assert property (@(posedge core_clk_in) disable iff (!nrst_in)
    (acc_v && !prod_sub && !acc_clr) |=> acc_r == ACC_W'($past(acc_r) + $past(p_ext)))
    else $error("accumulator did not add the product");
  acc_sub_a: assert property (@(posedge core_clk_in) disable iff (!nrst_in)
    (acc_v && prod_sub && !acc_clr) |=> acc_r == ACC_W'($past(acc_r) - $past(p_ext)))
    else $error("accumulator did not subtract the product");
  ovf_unsigned_a: assert property (@(posedge core_clk_in) disable iff (!nrst_in)
    (acc_v && !prod_sgn && !prod_sub && !acc_clr && (acc_sum[ACC_W-1:0] < acc_r)) |=> ovf_r ##1 overflow_out)
    else $error("unsigned roll-over not flagged");
  ovf_signed_a: assert property (@(posedge core_clk_in) disable iff (!nrst_in)
    (acc_v && prod_sgn && !prod_sub && !acc_clr && acc_msb == p_msb && acc_sum[ACC_W-1] != acc_msb) |=> ovf_r)
    else $error("signed overflow not flagged");
  ovf_pulse_a: assert property (@(posedge core_clk_in) disable iff (!nrst_in)
    (!acc_v) |=> !ovf_r ##1 !overflow_out)
    else $error("overflow held without a new event");
  ovf_clean_a: assert property (@(posedge core_clk_in) disable iff (!nrst_in)
    (acc_v && !prod_sgn && !prod_sub && !acc_clr && (acc_sum[ACC_W-1:0] >= acc_r)) |=> !ovf_r)
    else $error("overflow flagged with no roll-over");
  shift_load_a: assert property (@(posedge core_clk_in) disable iff (!nrst_in)
    a_shift |=> a_reg_r == $past(a_shift_in))
    else $error("operand register did not shift in");
  bus_answer_a: assert property (@(posedge core_clk_in) disable iff (!nrst_in)
    (req && wait_r) |=> !wait_r ##1 wait_r)
    else $error("waitrequest did not drop for exactly one cycle");
  irq_level_a: assert property (@(posedge core_clk_in) disable iff (!nrst_in)
    irq_out == |(status_r & mask_r))
    else $error("interrupt does not follow status and mask");
endmodule

// File: dsp_mac_pkg.sv
// Constants for the multiply and multiply-accumulate slice.
package dsp_mac_pkg;
  // Byte offsets of the register words
  localparam logic [3:0] CTRL_OFF = 4'h0;
  localparam logic [3:0] STATUS_OFF = 4'h4;
  localparam logic [3:0] MASK_OFF = 4'h8;
  localparam logic [3:0] RESULT_OFF = 4'hc;
  // Control word fields
  localparam int CTRL_MAC = 0;
  localparam int CTRL_IN_EN = 1;
  localparam int CTRL_PIPE_EN = 2;
  localparam int CTRL_OUT_EN = 3;
  localparam int CTRL_SIGN_DYN = 4;
  localparam int CTRL_SIGNED = 5;
  localparam int CTRL_SUB_DYN = 6;
  localparam int CTRL_SUB = 7;
  localparam int CTRL_A_SHIFT = 8;
  localparam int CTRL_B_SHIFT = 9;
  localparam int CTRL_ACC_CLR = 10;
  localparam int CTRL_W = 10;
  localparam logic [CTRL_W-1:0] CTRL_RST = 10'h000;
  // Status and mask fields
  localparam int ST_OVF = 0;
  localparam int ST_DONE = 1;
  localparam int ST_W = 2;
  localparam logic [ST_W-1:0] ST_RST = 2'h0;
  // Widest operand for which the accumulate element exists
  localparam int MAC_MAX_OP_W = 18;
  // Element counts per block for x9, x18, x36
  localparam int PROD_CNT [3] = '{8, 4, 1};
  localparam int MAC_CNT [3] = '{2, 2, 0};
  localparam int SUM_CNT [3] = '{4, 2, 0};
  localparam int SUM_TOTAL_CNT [3] = '{2, 1, 0};
endpackage

// File: product_stage.sv
// Signed or unsigned multiplier with a bypassable pipeline register.
module product_stage #(
  parameter int OP_W = 18
) (
  input wire logic core_clk_in,
  input wire logic nrst_in,
  input wire logic pipe_en_in,
  input wire logic valid_in,
  input wire logic signed_in,
  input wire logic sub_in,
  input wire logic [OP_W-1:0] a_in,
  input wire logic [OP_W-1:0] b_in,
  output logic [2*OP_W-1:0] prod_out,
  output logic valid_out,
  output logic signed_out,
  output logic sub_out
);
  // One extra bit carries the sign so one signed multiplier serves both modes
  wire logic signed [OP_W:0] a_x = {signed_in & a_in[OP_W-1], a_in};
  wire logic signed [OP_W:0] b_x = {signed_in & b_in[OP_W-1], b_in};
  wire logic signed [2*OP_W+1:0] full = a_x * b_x;
  wire logic [2*OP_W-1:0] prod_now = full[2*OP_W-1:0];

  logic [2*OP_W-1:0] prod_r;
  logic valid_r, signed_r, sub_r;

  always_ff @(posedge core_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      prod_r <= '0;
      valid_r <= 1'b0;
      signed_r <= 1'b0;
      sub_r <= 1'b0;
    end else begin
      prod_r <= prod_now;
      valid_r <= valid_in;
      signed_r <= signed_in;
      sub_r <= sub_in;
    end
  end

  assign prod_out = pipe_en_in ? prod_r : prod_now;
  assign valid_out = pipe_en_in ? valid_r : valid_in;
  assign signed_out = pipe_en_in ? signed_r : signed_in;
  assign sub_out = pipe_en_in ? sub_r : sub_in;

  pipe_delay_a: assert property (@(posedge core_clk_in) disable iff (!nrst_in)
    (pipe_en_in && valid_in) ##1 pipe_en_in |-> valid_out && prod_out == $past(prod_now))
    else $error("pipeline register did not delay the product by one cycle");
  prod_value_a: assert property (@(posedge core_clk_in) disable iff (!nrst_in)
    (!pipe_en_in && !signed_in) |-> prod_out == (2*OP_W)'({{OP_W{1'b0}}, a_in} * {{OP_W{1'b0}}, b_in}))
    else $error("unsigned product does not equal a times b");
endmodule

// File: fabric_source.sv
// Fabric-side operand source: widens narrow operands and counts overflow pulses.
module fabric_source (
  input wire logic core_clk_in,
  input wire logic nrst_in,
  input wire logic send_in,
  input wire logic sgn_in,
  input wire logic sub_in,
  input wire logic [8:0] a9_in,
  input wire logic [8:0] b9_in,
  input wire logic overflow_in,
  output logic valid_out,
  output logic [17:0] a_out,
  output logic [17:0] b_out,
  output logic signed_out,
  output logic sub_out,
  output logic [7:0] ovf_cnt_out
);
  always @(posedge core_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      valid_out <= 1'b0;
      a_out <= 18'h00000;
      b_out <= 18'h00000;
      signed_out <= 1'b0;
      sub_out <= 1'b0;
      ovf_cnt_out <= 8'h00;
    end else begin
      valid_out <= send_in;
      signed_out <= sgn_in;
      sub_out <= sub_in;
      if (send_in) begin
        a_out <= sgn_in ? {{9{a9_in[8]}}, a9_in} : {9'h000, a9_in};
        b_out <= sgn_in ? {{9{b9_in[8]}}, b9_in} : {9'h000, b9_in};
      end else begin
        // Operands are not held between samples, so stale data cannot pass for fresh
        a_out <= ~a_out;
        b_out <= ~b_out;
      end
      if (overflow_in) begin
        ovf_cnt_out <= ovf_cnt_out + 8'h01;
      end
    end
  end
endmodule

// File: dsp_multiply_accumulate_tb.sv
// Self-checking bench for the multiply and multiply-accumulate slice.
module dsp_multiply_accumulate_tb;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {logic [10:0] ctrl; logic [8:0] a; logic [8:0] b; logic sgn; logic sub;} row_s;
  localparam row_s ROWS [16] = '{
    '{11'h000, 9'h003, 9'h005, 1'b0, 1'b0}, '{11'h002, 9'h1ff, 9'h1ff, 1'b0, 1'b0},
    '{11'h004, 9'h00b, 9'h00d, 1'b0, 1'b0}, '{11'h008, 9'h011, 9'h013, 1'b0, 1'b0},
    '{11'h00e, 9'h100, 9'h0ff, 1'b0, 1'b0}, '{11'h020, 9'h1ff, 9'h003, 1'b1, 1'b0},
    '{11'h010, 9'h1fa, 9'h005, 1'b1, 1'b0}, '{11'h010, 9'h1fa, 9'h005, 1'b0, 1'b0},
    '{11'h102, 9'h0ff, 9'h003, 1'b0, 1'b0}, '{11'h302, 9'h0ff, 9'h0aa, 1'b0, 1'b0},
    '{11'h481, 9'h001, 9'h001, 1'b0, 1'b0}, '{11'h041, 9'h001, 9'h001, 1'b0, 1'b0},
    '{11'h041, 9'h003, 9'h005, 1'b0, 1'b0}, '{11'h041, 9'h002, 9'h003, 1'b0, 1'b1},
    '{11'h063, 9'h1fe, 9'h003, 1'b1, 1'b0}, '{11'h045, 9'h002, 9'h002, 1'b0, 1'b1}};
  logic core_clk_in = 1'b0;
  logic nrst_in = 1'b0;
  logic [3:0] adr = 4'h0;
  logic rd_req = 1'b0, wr_req = 1'b0, send = 1'b0, sgn = 1'b0, subr = 1'b0;
  logic [31:0] wdata = 32'h0, rdv, avs_readdata_out;
  logic [8:0] a9 = 9'h0, b9 = 9'h0;
  logic avs_waitrequest_out, irq_out, valid, sgn_w, sub_w, result_valid_out, overflow_out;
  logic [17:0] a, b, a_shift_out, b_shift_out;
  logic [51:0] result_out, acc, p, nx, exp_v;
  logic [7:0] ovf_cnt;
  logic [10:0] prev;
  logic s, sb, eo;
  int fails = 0, samples_checked = 0, ovfs = 0, n, lat;

  always #10 core_clk_in = ~core_clk_in;

  dsp_multiply_accumulate #(.OP_W(18), .ACC_W(52)) i_dsp_multiply_accumulate (
    .core_clk_in(core_clk_in), .nrst_in(nrst_in), .avs_address_in(adr), .avs_read_in(rd_req),
    .avs_write_in(wr_req), .avs_writedata_in(wdata), .avs_byteenable_in(4'hf),
    .avs_readdata_out(avs_readdata_out), .avs_waitrequest_out(avs_waitrequest_out), .irq_out(irq_out),
    .valid_in(valid), .a_in(a), .b_in(b), .a_shift_in(18'h00007), .b_shift_in(18'h00003),
    .signed_in(sgn_w), .sub_in(sub_w), .a_shift_out(a_shift_out), .b_shift_out(b_shift_out),
    .result_out(result_out), .result_valid_out(result_valid_out), .overflow_out(overflow_out));

  fabric_source i_fabric_source (
    .core_clk_in(core_clk_in), .nrst_in(nrst_in), .send_in(send), .sgn_in(sgn), .sub_in(subr),
    .a9_in(a9), .b9_in(b9), .overflow_in(overflow_out), .valid_out(valid), .a_out(a), .b_out(b),
    .signed_out(sgn_w), .sub_out(sub_w), .ovf_cnt_out(ovf_cnt));

  task chk(input logic [51:0] got, input logic [51:0] want, input string what);
    samples_checked++;
    if (got !== want) begin
      fails++;
      $display("[ERR] %0t %s got %h want %h", $time, what, got, want);
    end
  endtask

  // The request is held until waitrequest is seen low; no fixed wait count is assumed
  task bus(input logic wr, input logic [3:0] ad, input logic [31:0] wd);
    int k;
    k = 0;
    @(posedge core_clk_in);
    adr <= ad;
    wr_req <= wr;
    rd_req <= !wr;
    wdata <= wd;
    do begin
      @(posedge core_clk_in);
      k++;
    end while (avs_waitrequest_out !== 1'b0 && k < 20);
    rdv = avs_readdata_out;
    wr_req <= 1'b0;
    rd_req <= 1'b0;
    if (k >= 20) chk(1'b1, 1'b0, "bus answer");
  endtask

  function automatic logic [51:0] opnd(logic sh, logic [51:0] shv, logic [8:0] v, logic sg);
    return sh ? shv : (sg ? {{43{v[8]}}, v} : {43'h0, v});
  endfunction

  task sample(input row_s r);
    if (r.ctrl != prev) begin
      bus(1'b1, dsp_mac_pkg::CTRL_OFF, {21'h0, r.ctrl});
      prev = r.ctrl;
      if (r.ctrl[dsp_mac_pkg::CTRL_ACC_CLR]) acc = '0;
    end
    s = r.ctrl[dsp_mac_pkg::CTRL_SIGN_DYN] ? r.sgn : r.ctrl[dsp_mac_pkg::CTRL_SIGNED];
    sb = r.ctrl[dsp_mac_pkg::CTRL_SUB_DYN] ? r.sub : r.ctrl[dsp_mac_pkg::CTRL_SUB];
    p = opnd(r.ctrl[8] & r.ctrl[1], 52'h7, r.a, r.sgn) * opnd(r.ctrl[9] & r.ctrl[1], 52'h3, r.b, r.sgn);
    nx = sb ? acc - p : acc + p;
    if (sb) eo = s ? (acc[51] != p[51] && nx[51] != acc[51]) : (p > acc);
    else eo = s ? (acc[51] == p[51] && nx[51] != acc[51]) : (nx < acc);
    if (r.ctrl[0]) acc = nx;
    exp_v = r.ctrl[0] ? acc : p;
    eo = eo & r.ctrl[0];
    lat = r.ctrl[0] ? 2 + r.ctrl[1] + r.ctrl[2] : 1 + r.ctrl[1] + r.ctrl[2] + r.ctrl[3];
    @(posedge core_clk_in);
    send <= 1'b1;
    a9 <= r.a;
    b9 <= r.b;
    sgn <= r.sgn;
    subr <= r.sub;
    @(posedge core_clk_in);
    send <= 1'b0;
    n = 0;
    do begin
      @(posedge core_clk_in);
      #1;
      n++;
    end while (result_valid_out !== 1'b1 && n < 12);
    chk(n, lat, "latency");
    chk(result_out, exp_v, "result");
    chk(overflow_out, eo, "overflow");
    if (r.ctrl[8]) chk(a_shift_out, 52'h7, "shift reg");
    if (r.ctrl[9]) chk(b_shift_out, 52'h3, "shift reg b");
    if (eo) ovfs++;
    @(posedge core_clk_in);
    #1;
    chk(overflow_out, 1'b0, "pulse end");
  endtask

  task rst_chk;
    chk(result_out, 52'h0, "reset result");
    chk({overflow_out, irq_out, avs_waitrequest_out, result_valid_out}, 4'h2, "reset flags");
    chk({b_shift_out, a_shift_out}, 36'h0, "reset shift regs");
    chk(avs_readdata_out, 32'h0, "reset readdata");
  endtask

  task complete_run;
    $display("fails=%0d samples_checked=%0d", fails, samples_checked);
    if (fails == 0 && samples_checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  initial begin
    #100000;
    fails++;
    complete_run;
  end

  initial begin
    acc = '0;
    prev = '0;
    repeat (3) @(posedge core_clk_in);
    #1;
    rst_chk();
    @(posedge core_clk_in);
    nrst_in <= 1'b1;
    bus(1'b1, dsp_mac_pkg::MASK_OFF, 32'h1);
    foreach (ROWS[i]) sample(ROWS[i]);
    chk(irq_out, 1'b1, "irq on overflow");
    bus(1'b0, dsp_mac_pkg::RESULT_OFF, 32'h0);
    chk(rdv, acc[31:0], "result reg");
    bus(1'b1, dsp_mac_pkg::RESULT_OFF, 32'h12345678);
    bus(1'b0, dsp_mac_pkg::RESULT_OFF, 32'h0);
    chk(rdv, acc[31:0], "result read-only");
    bus(1'b0, 4'h2, 32'h0);
    chk(rdv, 32'h0, "unmapped");
    bus(1'b0, dsp_mac_pkg::STATUS_OFF, 32'h0);
    chk(rdv[1:0], 2'h3, "status");
    bus(1'b0, dsp_mac_pkg::STATUS_OFF, 32'h0);
    chk(rdv[1:0], 2'h0, "status cleared");
    repeat (2) @(posedge core_clk_in);
    #1;
    chk(irq_out, 1'b0, "irq cleared");
    bus(1'b1, dsp_mac_pkg::MASK_OFF, 32'h2);
    sample(ROWS[0]);
    repeat (2) @(posedge core_clk_in);
    #1;
    chk(irq_out, 1'b1, "irq on done");
    bus(1'b1, dsp_mac_pkg::MASK_OFF, 32'h0);
    repeat (2) @(posedge core_clk_in);
    #1;
    chk(irq_out, 1'b0, "irq masked");
    chk(ovf_cnt, ovfs, "pulse count");
    @(posedge core_clk_in);
    nrst_in <= 1'b0;
    repeat (3) @(posedge core_clk_in);
    #1;
    rst_chk();
    @(posedge core_clk_in);
    nrst_in <= 1'b1;
    bus(1'b0, dsp_mac_pkg::CTRL_OFF, 32'h0);
    chk(rdv, 32'h0, "ctrl after reset");
    complete_run;
  end
endmodule
